// [rtl/ldh_ctrl.sv]
`timescale 1ns/1ps
module ldh_ctrl
	import ldh_pkg::*;
#(
	parameter int unsigned SS_CYC = SS_STEP_CYC
) (
	input  wire logic              sys_clk,
	input  wire logic              reset_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              chip_enable,
	input  wire logic              dim_in,
	input  wire logic              phase_shift_select,
	input  wire logic              overtemp_in,
	input  wire logic              fault_output_n_in,
	input  wire logic [NSTR-1:0]   sink_below_low,
	input  wire logic [NSTR-1:0]   sink_above_high,
	input  wire logic [NSTR-1:0]   sink_open,
	input  wire logic [NSTR-1:0]   sink_short,
	input  wire logic [NSTR-1:0]   sink_unused,
	output logic [NSTR-1:0]        string_dim_en,
	output logic                   boost_gate_en,
	output logic                   boost_sync,
	output logic                   comp_connect,
	output logic [DAC_W-1:0]       dac_code,
	output logic                   fault_output_n_out,
	output logic                   fault_output_n_oe
);
	localparam int unsigned IN_W = 5 + 5 * NSTR;

	ldh_hr_if hr_if ();

	// Count strings in use below a given position
	function automatic logic [2:0] count_used(input logic [NSTR-1:0] unused,
		input int unsigned upto);
		logic [2:0] c;
		c = 3'd0;
		for (int j = 0; j < NSTR; j++) begin
			if (j < upto && !unused[j]) begin
				c = c + 3'd1;
			end
		end
		return c;
	endfunction

	// Two-flop synchronisers for all input pins except the APB bus
	logic [IN_W-1:0] in_raw;
	logic [IN_W-1:0] s1_r;
	logic [IN_W-1:0] s2_r;
	logic            en_s;
	logic            dim_s;
	logic            pss_s;
	logic            ot_s;
	logic            fpin_s;
	logic [NSTR-1:0] below_s;
	logic [NSTR-1:0] above_s;
	logic [NSTR-1:0] open_s;
	logic [NSTR-1:0] short_s;
	logic [NSTR-1:0] unused_s;

	assign in_raw = {chip_enable, dim_in, phase_shift_select, overtemp_in, fault_output_n_in,
		sink_below_low, sink_above_high, sink_open, sink_short, sink_unused};

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			s1_r <= '0;
			s2_r <= '0;
		end else begin
			s1_r <= in_raw;
			s2_r <= s1_r;
		end
	end

	assign {en_s, dim_s, pss_s, ot_s, fpin_s, below_s, above_s, open_s, short_s, unused_s} = s2_r;

	// Control state
	ldh_state_t      state_r, state_nxt;
	logic [2:0]      smp_cnt_r, smp_cnt_nxt;
	logic            dim_q_r, dim_q_nxt;
	logic [1:0]      det_r, det_nxt;
	logic [PER_W-1:0] per_cnt_r, per_cnt_nxt;
	logic [PER_W-1:0] period_r, period_nxt;
	logic [PER_W-1:0] phase_r, phase_nxt;
	logic [PER_W-1:0] on_cnt_r, on_cnt_nxt;
	logic [PER_W-1:0] on_meas_r, on_meas_nxt;
	logic [PER_W-1:0] on_app_r, on_app_nxt;
	logic [PER_W-1:0] div_rem_r, div_rem_nxt;
	logic [PER_W-1:0] step_r, step_nxt;
	logic            offs_ready_r, offs_ready_nxt;
	logic            low_dim_r, low_dim_nxt;
	logic [NSTR-1:0] unused_mask_r, unused_mask_nxt;
	logic [NSTR-1:0] disc_r, disc_nxt;
	logic [NSTR-1:0] str_en_r, str_en_nxt;
	logic            gate_r, gate_nxt;
	logic            bsync_r, bsync_nxt;
	logic            comp_r, comp_nxt;
	logic            fault_oe_r, fault_oe_nxt;
	logic [1:0]      pwr_cnt_r, pwr_cnt_nxt;
	logic            ps_lat_r, ps_lat_nxt;
	logic            ctrl_fsw_r, ctrl_fsw_nxt;

	logic            tick;
	logic            rise;
	logic            fall;
	logic            running;
	logic [2:0]      n_used;
	logic [NSTR-1:0] active;
	logic [NSTR-1:0] win;
	logic [PER_W-1:0] ld_enter;
	logic [PER_W-1:0] ld_exit;

	// Dim sampled on a 10 MHz tick
	assign tick     = (smp_cnt_r == 3'(SMP_DIV - 1));
	assign rise     = tick & dim_s & ~dim_q_r;
	assign fall     = tick & ~dim_s & dim_q_r;
	assign running  = (state_r == ST_RUN);
	assign n_used   = count_used(unused_mask_r, NSTR);
	assign active   = ~unused_mask_r & ~disc_r;
	assign ld_enter = ctrl_fsw_r ? LD_ENTER_FAST_TK : LD_ENTER_SLOW_TK;
	assign ld_exit  = ctrl_fsw_r ? LD_EXIT_FAST_TK : LD_EXIT_SLOW_TK;

	// Per-string dimming window, offset by fixed 360/n slots
	generate
		for (genvar g = 0; g < NSTR; g++) begin : g_str
			logic [PER_W-1:0] offs;
			logic [PER_W-1:0] rel;
			assign offs = ps_lat_r ? PER_W'(step_r * count_used(unused_mask_r, g)) : '0;
			assign rel  = (phase_r >= offs) ? phase_r - offs : phase_r + period_r - offs;
			assign win[g] = (rel < on_app_r);
		end
	endgenerate

	always_comb begin
		state_nxt       = state_r;
		smp_cnt_nxt     = tick ? 3'd0 : smp_cnt_r + 3'd1;
		dim_q_nxt       = tick ? dim_s : dim_q_r;
		det_nxt         = det_r;
		per_cnt_nxt     = per_cnt_r;
		period_nxt      = period_r;
		phase_nxt       = phase_r;
		on_cnt_nxt      = on_cnt_r;
		on_meas_nxt     = on_meas_r;
		on_app_nxt      = on_app_r;
		div_rem_nxt     = div_rem_r;
		step_nxt        = step_r;
		offs_ready_nxt  = offs_ready_r;
		low_dim_nxt     = low_dim_r;
		unused_mask_nxt = unused_mask_r;
		disc_nxt        = disc_r;
		pwr_cnt_nxt     = pwr_cnt_r;
		ps_lat_nxt      = ps_lat_r;
		// Phase select caught once after reset release
		if (pwr_cnt_r != 2'd3) begin
			pwr_cnt_nxt = pwr_cnt_r + 2'd1;
			if (pwr_cnt_r == 2'd2) begin
				ps_lat_nxt = pss_s;
			end
		end
		case (state_r)
			ST_OFF: begin
				if (en_s) begin
					state_nxt = ST_CHECK;
				end
			end
			ST_CHECK: begin
				unused_mask_nxt = unused_s;
				state_nxt       = ST_SOFT;
			end
			ST_SOFT: begin
				if (hr_if.ss_done && offs_ready_r) begin
					state_nxt = ST_RUN;
				end
			end
			default: begin
			end
		endcase
		// Dimming frequency from the first two rising edges
		if (tick && det_r != 2'd2 && state_r != ST_OFF) begin
			per_cnt_nxt = per_cnt_r + 20'h00001;
			if (rise) begin
				per_cnt_nxt = '0;
				if (det_r == 2'd1) begin
					period_nxt  = per_cnt_r + 20'h00001;
					div_rem_nxt = per_cnt_r + 20'h00001;
					step_nxt    = '0;
					det_nxt     = 2'd2;
				end else begin
					det_nxt = 2'd1;
				end
			end
		end
		// Slot width = period / strings in use
		if (det_r == 2'd2 && !offs_ready_r) begin
			if (n_used == 3'd0 || div_rem_r < PER_W'(n_used)) begin
				offs_ready_nxt = 1'b1;
			end else begin
				div_rem_nxt = div_rem_r - PER_W'(n_used);
				step_nxt    = step_r + 20'h00001;
			end
		end
		// Phase and on-time tracking once the period is measured
		if (tick && det_r == 2'd2) begin
			phase_nxt = (phase_r == period_r - 20'h00001) ? '0 : phase_r + 20'h00001;
			if (dim_s) begin
				on_cnt_nxt = on_cnt_r + 20'h00001;
			end
			if (rise) begin
				phase_nxt  = '0;
				on_cnt_nxt = 20'h00001;
				on_app_nxt = on_meas_r;
			end
			if (fall) begin
				on_meas_nxt = on_cnt_r;
				if (on_cnt_r < ld_enter) begin
					low_dim_nxt = 1'b1;
				end else if (on_cnt_r > ld_exit) begin
					low_dim_nxt = 1'b0;
				end
			end
		end
		// Latch faulty strings out of the dimming control
		if (running) begin
			disc_nxt = disc_r | (open_s & str_en_r & ~unused_mask_r)
				| (short_s & str_en_r & {NSTR{~low_dim_r}});
		end
		if (ot_s && state_r != ST_OFF) begin
			state_nxt = ST_HOT;
		end
		// Enable low clears the control state, frequency included; phase select stays latched
		if (!en_s) begin
			state_nxt       = ST_OFF;
			det_nxt         = 2'd0;
			per_cnt_nxt     = '0;
			period_nxt      = '0;
			phase_nxt       = '0;
			on_cnt_nxt      = '0;
			on_meas_nxt     = '0;
			on_app_nxt      = '0;
			div_rem_nxt     = '0;
			step_nxt        = '0;
			offs_ready_nxt  = 1'b0;
			low_dim_nxt     = 1'b0;
			unused_mask_nxt = '0;
			disc_nxt        = '0;
		end
	end

	// Outputs toward sinks, boost and fault pin
	always_comb begin
		str_en_nxt = running ? (win & active) : '0;
		gate_nxt   = (state_r == ST_SOFT) | (running & (low_dim_r | (|str_en_nxt)));
		comp_nxt   = gate_nxt;
		bsync_nxt  = running & (|(str_en_nxt & ~str_en_r));
		fault_oe_nxt = (|disc_r) | (state_r == ST_HOT);
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r       <= ST_OFF;
			smp_cnt_r     <= '0;
			dim_q_r       <= 1'b0;
			det_r         <= '0;
			per_cnt_r     <= '0;
			period_r      <= '0;
			phase_r       <= '0;
			on_cnt_r      <= '0;
			on_meas_r     <= '0;
			on_app_r      <= '0;
			div_rem_r     <= '0;
			step_r        <= '0;
			offs_ready_r  <= 1'b0;
			low_dim_r     <= 1'b0;
			unused_mask_r <= '0;
			disc_r        <= '0;
			str_en_r      <= '0;
			gate_r        <= 1'b0;
			bsync_r       <= 1'b0;
			comp_r        <= 1'b0;
			fault_oe_r    <= 1'b0;
			pwr_cnt_r     <= '0;
			ps_lat_r      <= 1'b0;
		end else begin
			state_r       <= state_nxt;
			smp_cnt_r     <= smp_cnt_nxt;
			dim_q_r       <= dim_q_nxt;
			det_r         <= det_nxt;
			per_cnt_r     <= per_cnt_nxt;
			period_r      <= period_nxt;
			phase_r       <= phase_nxt;
			on_cnt_r      <= on_cnt_nxt;
			on_meas_r     <= on_meas_nxt;
			on_app_r      <= on_app_nxt;
			div_rem_r     <= div_rem_nxt;
			step_r        <= step_nxt;
			offs_ready_r  <= offs_ready_nxt;
			low_dim_r     <= low_dim_nxt;
			unused_mask_r <= unused_mask_nxt;
			disc_r        <= disc_nxt;
			str_en_r      <= str_en_nxt;
			gate_r        <= gate_nxt;
			bsync_r       <= bsync_nxt;
			comp_r        <= comp_nxt;
			fault_oe_r    <= fault_oe_nxt;
			pwr_cnt_r     <= pwr_cnt_nxt;
			ps_lat_r      <= ps_lat_nxt;
		end
	end

	// Headroom counter hookup
	assign hr_if.enable    = (state_r != ST_OFF) && (state_r != ST_HOT);
	assign hr_if.ss_active = (state_r == ST_SOFT);
	assign hr_if.update    = running & fall;
	assign hr_if.any_low   = |(below_s & active);
	assign hr_if.all_high  = (|active) & (&(above_s | ~active));

	ldh_headroom #(
		.SS_CYC (SS_CYC)
	) u_headroom (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.hr      (hr_if.hr)
	);

	// APB slave: one access cycle, error on unmapped address
	logic [7:0]  ss_target_r, ss_target_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic        pready_r, pready_nxt;
	logic        pslverr_r, pslverr_nxt;
	logic [31:0] rd;
	logic        bad;

	assign hr_if.ss_target = ss_target_r;

	always_comb begin
		rd  = '0;
		bad = 1'b0;
		if (paddr == REG_CTRL) begin
			rd[CTRL_FSW_BIT] = ctrl_fsw_r;
		end else if (paddr == REG_SS_TARGET) begin
			rd[DAC_W-1:0] = ss_target_r;
		end else if (paddr == REG_STATUS) begin
			rd[ST_STATE_LSB +: 3] = state_r;
			rd[ST_LOWDIM_BIT]     = low_dim_r;
			rd[ST_PHASE_BIT]      = ps_lat_r;
			rd[ST_LOCK_BIT]       = offs_ready_r;
			rd[ST_FAULT_BIT]      = fault_oe_r;
			rd[ST_PIN_BIT]        = fpin_s;
		end else if (paddr == REG_STRINGS) begin
			rd[STR_UNUSED_LSB +: NSTR] = unused_mask_r;
			rd[STR_DISC_LSB +: NSTR]   = disc_r;
			rd[STR_EN_LSB +: NSTR]     = str_en_r;
		end else if (paddr == REG_PERIOD) begin
			rd[PER_W-1:0] = period_r;
		end else if (paddr == REG_ONTIME) begin
			rd[PER_W-1:0] = on_app_r;
		end else if (paddr == REG_DAC) begin
			rd[DAC_W-1:0] = hr_if.dac_code;
		end else begin
			bad = 1'b1;
		end
		ctrl_fsw_nxt  = ctrl_fsw_r;
		ss_target_nxt = ss_target_r;
		prdata_nxt    = prdata_r;
		pready_nxt    = 1'b0;
		pslverr_nxt   = 1'b0;
		if (psel && !penable) begin
			pready_nxt  = 1'b1;
			pslverr_nxt = bad;
			prdata_nxt  = pwrite ? 32'h0000_0000 : rd;
		end
		if (psel && penable && pready_r && pwrite && !pslverr_r) begin
			if (paddr == REG_CTRL) begin
				ctrl_fsw_nxt = pwdata[CTRL_FSW_BIT];
			end else if (paddr == REG_SS_TARGET) begin
				ss_target_nxt = pwdata[DAC_W-1:0];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_fsw_r  <= CTRL_FSW_RST;
			ss_target_r <= SS_TARGET_RST;
			prdata_r    <= '0;
			pready_r    <= 1'b0;
			pslverr_r   <= 1'b0;
		end else begin
			ctrl_fsw_r  <= ctrl_fsw_nxt;
			ss_target_r <= ss_target_nxt;
			prdata_r    <= prdata_nxt;
			pready_r    <= pready_nxt;
			pslverr_r   <= pslverr_nxt;
		end
	end

	// Output drive, all from flops except the fault pin level, tied low
	assign prdata             = prdata_r;
	assign pready             = pready_r;
	assign pslverr            = pslverr_r;
	assign string_dim_en      = str_en_r;
	assign boost_gate_en      = gate_r;
	assign boost_sync         = bsync_r;
	assign comp_connect       = comp_r;
	assign dac_code           = hr_if.dac_code;
	assign fault_output_n_out = 1'b0;
	assign fault_output_n_oe  = fault_oe_r;
endmodule

// [rtl/ldh_headroom.sv]
`timescale 1ns/1ps
module ldh_headroom
	import ldh_pkg::*;
#(
	parameter int unsigned SS_CYC = SS_STEP_CYC
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	ldh_hr_if.hr     hr
);
	logic [DAC_W-1:0] code_r;
	logic [DAC_W-1:0] code_nxt;
	logic [23:0]      ss_cnt_r;
	logic [23:0]      ss_cnt_nxt;
	logic             done_r;
	logic             done_nxt;

	// Soft-start ramp, then window-driven up/down counting
	always_comb begin
		code_nxt   = code_r;
		ss_cnt_nxt = ss_cnt_r;
		done_nxt   = done_r;
		if (!hr.enable) begin
			code_nxt   = DAC_CODE_MIN;
			ss_cnt_nxt = '0;
			done_nxt   = 1'b0;
		end else if (hr.ss_active && !done_r) begin
			if (ss_cnt_r == 24'(SS_CYC - 1)) begin
				ss_cnt_nxt = '0;
				if (code_r >= hr.ss_target || code_r == DAC_CODE_MAX) begin
					done_nxt = 1'b1;
				end else begin
					code_nxt = code_r + 8'h01;
				end
			end else begin
				ss_cnt_nxt = ss_cnt_r + 24'h000001;
			end
		end else if (hr.update) begin
			if (hr.any_low) begin
				if (code_r < DAC_CODE_MAX) begin
					code_nxt = code_r + 8'h01;
				end
			end else if (hr.all_high && code_r > DAC_CODE_MIN) begin
				code_nxt = code_r - 8'h01;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			code_r   <= DAC_CODE_MIN;
			ss_cnt_r <= '0;
			done_r   <= 1'b0;
		end else begin
			code_r   <= code_nxt;
			ss_cnt_r <= ss_cnt_nxt;
			done_r   <= done_nxt;
		end
	end

	assign hr.dac_code = code_r;
	assign hr.ss_done  = done_r;
endmodule

// [rtl/ldh_hr_if.sv]
`timescale 1ns/1ps
interface ldh_hr_if;
	import ldh_pkg::*;
	logic             enable;
	logic             ss_active;
	logic             update;
	logic             any_low;
	logic             all_high;
	logic [DAC_W-1:0] ss_target;
	logic [DAC_W-1:0] dac_code;
	logic             ss_done;

	modport ctrl (output enable, ss_active, update, any_low, all_high, ss_target,
		input dac_code, ss_done);
	modport hr (input enable, ss_active, update, any_low, all_high, ss_target,
		output dac_code, ss_done);
endinterface

// [rtl/ldh_pkg.sv]
package ldh_pkg;

	// Clocks and sampling
	localparam int unsigned SYS_HZ  = 50_000_000;
	localparam int unsigned SYS_NS  = 20;
	localparam int unsigned SMP_HZ  = 10_000_000;
	localparam int unsigned SMP_DIV = SYS_HZ / SMP_HZ;
	localparam int unsigned SMP_NS  = 1_000_000_000 / SMP_HZ;

	// Structure
	localparam int unsigned NSTR  = 6;
	localparam int unsigned PER_W = 20;
	localparam int unsigned DAC_W = 8;

	// Low-dim thresholds, in ns and in sample ticks
	localparam int unsigned LD_ENTER_SLOW_NS = 50_000;
	localparam int unsigned LD_EXIT_SLOW_NS  = 51_000;
	localparam int unsigned LD_ENTER_FAST_NS = 25_000;
	localparam int unsigned LD_EXIT_FAST_NS  = 26_000;
	localparam logic [PER_W-1:0] LD_ENTER_SLOW_TK = PER_W'(LD_ENTER_SLOW_NS / SMP_NS);
	localparam logic [PER_W-1:0] LD_EXIT_SLOW_TK  = PER_W'(LD_EXIT_SLOW_NS / SMP_NS);
	localparam logic [PER_W-1:0] LD_ENTER_FAST_TK = PER_W'(LD_ENTER_FAST_NS / SMP_NS);
	localparam logic [PER_W-1:0] LD_EXIT_FAST_TK  = PER_W'(LD_EXIT_FAST_NS / SMP_NS);

	// DAC scale: code 0 is the lower clamp
	localparam int unsigned DAC_LSB_UV = 2_500;
	localparam int unsigned DAC_MIN_UV = 600_000;
	localparam int unsigned DAC_MAX_UV = 1_250_000;
	localparam int unsigned DAC_SPAN   = (DAC_MAX_UV - DAC_MIN_UV) / DAC_LSB_UV;
	localparam logic [DAC_W-1:0] DAC_CODE_MIN = 8'h00;
	localparam logic [DAC_W-1:0] DAC_CODE_MAX = (DAC_SPAN > 255) ? 8'hFF : DAC_W'(DAC_SPAN);

	// Soft-start step time
	localparam int unsigned SS_STEP_NS  = 196_000;
	localparam int unsigned SS_STEP_CYC = SS_STEP_NS / SYS_NS;

	// Register map (byte addresses)
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_SS_TARGET = 8'h04;
	localparam logic [7:0] REG_STATUS    = 8'h08;
	localparam logic [7:0] REG_STRINGS   = 8'h0C;
	localparam logic [7:0] REG_PERIOD    = 8'h10;
	localparam logic [7:0] REG_ONTIME    = 8'h14;
	localparam logic [7:0] REG_DAC       = 8'h18;

	// Fields and reset values
	localparam int unsigned CTRL_FSW_BIT   = 0;
	localparam logic        CTRL_FSW_RST   = 1'b0;
	localparam logic [7:0]  SS_TARGET_RST  = 8'h80;
	localparam int unsigned ST_STATE_LSB   = 0;
	localparam int unsigned ST_LOWDIM_BIT  = 4;
	localparam int unsigned ST_PHASE_BIT   = 5;
	localparam int unsigned ST_LOCK_BIT    = 6;
	localparam int unsigned ST_FAULT_BIT   = 7;
	localparam int unsigned ST_PIN_BIT     = 8;
	localparam int unsigned STR_UNUSED_LSB = 0;
	localparam int unsigned STR_DISC_LSB   = 8;
	localparam int unsigned STR_EN_LSB     = 16;

	typedef enum logic [2:0] {ST_OFF, ST_CHECK, ST_SOFT, ST_RUN, ST_HOT} ldh_state_t;

endpackage

// [verif/ldh_ctrl_monitor.sv]
`timescale 1ns/1ps
module ldh_ctrl_monitor
	import ldh_pkg::*;
#(
	parameter int unsigned SS_CYC = SS_STEP_CYC
) (
	input wire logic             sys_clk,
	input wire logic             reset_n,
	input wire logic             psel,
	input wire logic             penable,
	input wire logic             pready,
	input wire logic             pslverr,
	input wire logic             chip_enable,
	input wire logic             overtemp_in,
	input wire logic [NSTR-1:0]  string_dim_en,
	input wire logic             boost_gate_en,
	input wire logic             boost_sync,
	input wire logic             comp_connect,
	input wire logic [DAC_W-1:0] dac_code,
	input wire logic             fault_output_n_out,
	input wire logic             fault_output_n_oe
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	// Bus answer timing
	chk_pready_one: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("pready not a single cycle after setup");
	chk_err_pair: assert property (pslverr |-> pready)
		else $error("pslverr without pready");

	// Pin level and power state
	chk_off_quiet: assert property (!chip_enable [*6] |->
		string_dim_en == '0 && !boost_gate_en && !fault_output_n_oe)
		else $error("outputs active while disabled");
	chk_fault_low: assert property (fault_output_n_out == 1'b0)
		else $error("fault pin driven high");
	chk_hot_off: assert property ($rose(overtemp_in) && chip_enable |->
		##[1:8] (fault_output_n_oe && string_dim_en == '0 && !boost_gate_en))
		else $error("overtemperature did not shut down");

	// Switching control
	chk_gate_comp: assert property (boost_gate_en == comp_connect)
		else $error("compensation link differs from gate enable");
	chk_sync_pulse: assert property (boost_sync |-> (|string_dim_en) ##1 !boost_sync)
		else $error("boost sync pulse wrong");

	// Reference code moves one step at a time
	chk_dac_step: assert property (chip_enable && $past(chip_enable, 6) &&
		!overtemp_in && !$past(overtemp_in, 6) && $changed(dac_code) |->
		dac_code == $past(dac_code) + 8'h01 || dac_code == $past(dac_code) - 8'h01)
		else $error("dac code jumped");

	cover property (boost_sync);
	cover property (pslverr);
	cover property ($rose(fault_output_n_oe));
endmodule

bind ldh_ctrl ldh_ctrl_monitor #(.SS_CYC(SS_CYC)) u_mon (
	.sys_clk            (sys_clk),
	.reset_n            (reset_n),
	.psel               (psel),
	.penable            (penable),
	.pready             (pready),
	.pslverr            (pslverr),
	.chip_enable        (chip_enable),
	.overtemp_in        (overtemp_in),
	.string_dim_en      (string_dim_en),
	.boost_gate_en      (boost_gate_en),
	.boost_sync         (boost_sync),
	.comp_connect       (comp_connect),
	.dac_code           (dac_code),
	.fault_output_n_out (fault_output_n_out),
	.fault_output_n_oe  (fault_output_n_oe)
);

// [verif/ldh_host.sv]
`timescale 1ns/1ps
module ldh_host (
	input wire logic        sys_clk,
	input wire logic        en_req,
	input wire logic [15:0] per,
	input wire logic [15:0] on,
	output logic            chip_enable,
	output logic            dim_in
);
	logic [15:0] cnt = 16'h0000;

	initial chip_enable = 1'b0;
	initial dim_in = 1'b0;

	// Dim waveform; enable rises only at a period start
	always @(posedge sys_clk) begin
		cnt <= (cnt + 16'h0001 >= per) ? 16'h0000 : cnt + 16'h0001;
		dim_in <= (cnt < on);
		if (cnt == 16'h0000 || !en_req) begin
			chip_enable <= en_req;
		end
	end
endmodule

// [verif/tb_led_dimming_headroom_ctrl.sv]
`timescale 1ns/1ps
module tb_led_dimming_headroom_ctrl;
	import ldh_pkg::*;
	logic        sys_clk, reset_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, dac;
	logic [31:0] pwdata, prdata;
	logic        chip_enable, dim_in, phase_shift_select, overtemp_in, en_req;
	logic        gate, sync, comp, f_out, f_oe, f_pin;
	logic [5:0]  below, above, opn, shrt, unused, dim_en;
	logic [15:0] per, on;
	int          fail_count = 0;
	int          n_checks = 0;

	// Fault pin with pull-up
	assign f_pin = f_oe ? f_out : 1'b1;

	ldh_ctrl #(.SS_CYC(4)) u_dut (
		.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .chip_enable(chip_enable),
		.dim_in(dim_in), .phase_shift_select(phase_shift_select),
		.overtemp_in(overtemp_in), .fault_output_n_in(f_pin),
		.sink_below_low(below), .sink_above_high(above), .sink_open(opn),
		.sink_short(shrt), .sink_unused(unused), .string_dim_en(dim_en),
		.boost_gate_en(gate), .boost_sync(sync), .comp_connect(comp),
		.dac_code(dac), .fault_output_n_out(f_out), .fault_output_n_oe(f_oe));

	ldh_host u_host (.sys_clk(sys_clk), .en_req(en_req), .per(per), .on(on),
		.chip_enable(chip_enable), .dim_in(dim_in));

	// Clock
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	task automatic conclude;
		if (fail_count == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_checks++;
		if (g !== x) begin
			fail_count++;
			$display("BAD %0t got %h expected %h", $time, g, x);
		end
	endtask

	task automatic tmo;
		fail_count++;
		$display("BAD %0t wait ran out", $time);
		conclude();
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) tmo();
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		logic e;
		apb(1'b0, a, 32'h0, q, e);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic wait_run;
		logic [31:0] q;
		for (int i = 0; i < 100; i++) begin
			rd(REG_STATUS, q);
			if (q[2:0] === 3'h3) return;
			repeat (200) @(posedge sys_clk);
		end
		tmo();
	endtask

	task automatic wait_en(input logic v);
		for (int i = 0; i < 4000; i++) begin
			if ((|dim_en) === v) return;
			@(posedge sys_clk);
		end
		tmo();
	endtask

	task automatic t_regs;
		logic [31:0] q;
		logic e;
		rd(REG_SS_TARGET, q);
		chk(q, {24'h0, SS_TARGET_RST});
		wr(REG_SS_TARGET, 32'h04);
		rd(REG_SS_TARGET, q);
		chk(q, 32'h04);
		wr(REG_STATUS, 32'hFF);
		rd(REG_STATUS, q);
		chk(q[2:0], 3'h0);
		apb(1'b0, 8'h40, 32'h0, q, e);
		chk(e, 1'b1);
	endtask

	task automatic t_mode(input logic f, input logic [15:0] o, input logic x);
		logic [31:0] q;
		wr(REG_CTRL, {31'h0, f});
		on <= o;
		repeat (6000) @(posedge sys_clk);
		rd(REG_STATUS, q);
		chk(q[ST_LOWDIM_BIT], x);
		wait_en(1'b1);
		wait_en(1'b0);
		repeat (3) @(posedge sys_clk);
		chk(gate, x);
	endtask

	task automatic t_dac(input logic [5:0] lo, input logic [5:0] hi, input logic [7:0] d);
		logic [31:0] a, b;
		logic [7:0] c;
		below <= lo;
		above <= hi;
		repeat (4) @(posedge sys_clk); // Let the window levels pass the synchroniser
		rd(REG_DAC, a);
		repeat (2997) @(posedge sys_clk);
		rd(REG_DAC, b);
		c = a[7:0] + d;
		chk(b[7:0], c);
	endtask

	task automatic t_phase(input logic [5:0] m);
		int t [6];
		logic [5:0] p;
		for (int i = 0; i < 6; i++) t[i] = -1;
		p = dim_en;
		for (int c = 0; c < 3000; c++) begin
			@(posedge sys_clk);
			for (int i = 0; i < 6; i++) if (dim_en[i] && !p[i] && t[i] < 0) t[i] = c;
			p = dim_en;
		end
		for (int i = 0; i < 6; i++)
			chk(m[i] ? (t[i] - t[0] + 3000) % 3000 : t[i], m[i] ? i * 600 : -1);
	endtask

	// Main sequence
	initial begin
		logic [31:0] q;
		reset_n = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{phase_shift_select, overtemp_in, en_req} = '0;
		{below, above, opn, shrt, unused} = '0;
		per = 16'd3000;
		on = 16'd2600;
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		t_regs();
		en_req <= 1'b1;
		wait_run();
		rd(REG_PERIOD, q);
		chk(q, 32'd600);
		repeat (6000) @(posedge sys_clk);
		rd(REG_ONTIME, q);
		chk(q, 32'd520);
		wait_en(1'b1);
		chk(dim_en, 6'h3F);
		t_mode(1'b0, 16'd1500, 1'b1);
		t_mode(1'b0, 16'd2600, 1'b0);
		t_mode(1'b1, 16'd1500, 1'b0);
		t_mode(1'b0, 16'd2600, 1'b0);
		t_dac(6'h3F, 6'h00, 8'h01);
		t_dac(6'h01, 6'h00, 8'h01);
		t_dac(6'h00, 6'h3F, 8'hFF);
		t_dac(6'h00, 6'h1F, 8'h00);
		per <= 16'd2000;
		on <= 16'd1000;
		repeat (4000) @(posedge sys_clk);
		rd(REG_PERIOD, q);
		chk(q, 32'd600);
		en_req <= 1'b0;
		repeat (20) @(posedge sys_clk);
		chk(dim_en, 6'h00);
		en_req <= 1'b1;
		wait_run();
		rd(REG_PERIOD, q);
		chk(q, 32'd400);
		en_req <= 1'b0;
		per <= 16'd3000;
		on <= 16'd2600;
		repeat (20) @(posedge sys_clk);
		reset_n <= 1'b0;
		phase_shift_select <= 1'b1;
		unused <= 6'h20;
		opn <= 6'h20; // Unused sink also looks open
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'b1;
		en_req <= 1'b1;
		wait_run();
		repeat (3000) @(posedge sys_clk);
		t_phase(6'h1F);
		rd(REG_STATUS, q);
		chk(q[8:7], 2'b10);
		shrt <= 6'h04;
		repeat (6000) @(posedge sys_clk);
		t_phase(6'h1B);
		rd(REG_STATUS, q);
		chk(q[8:7], 2'b01);
		overtemp_in <= 1'b1;
		repeat (20) @(posedge sys_clk);
		rd(REG_STATUS, q);
		chk(q[2:0], 3'h4);
		chk(dim_en, 6'h00);
		conclude();
	end
endmodule
